// ==== sac_pkg.sv ====
// Constants, types and register map of the successive-approximation control block.
// Assumes a 250 MHz system clock and a 32-bit APB register bus.
`default_nettype none
package sac_pkg;

   // ----------------------------------------------------------------
   // Register indices and byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_CODE = 8'h02;
   localparam logic [7:0] IDX_CHAN = 8'h24;
   localparam logic [7:0] IDX_MODE = 8'h25;
   localparam logic [7:0] IDX_ISTAT = 8'h30;
   localparam logic [7:0] IDX_IMASK = 8'h31;
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_CODE = {2'h0, IDX_CODE, 2'h0};
   localparam logic [11:0] ADDR_CHAN = {2'h0, IDX_CHAN, 2'h0};
   localparam logic [11:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
   localparam logic [11:0] ADDR_ISTAT = {2'h0, IDX_ISTAT, 2'h0};
   localparam logic [11:0] ADDR_IMASK = {2'h0, IDX_IMASK, 2'h0};

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int MODE_RES_BIT = 0;
   localparam int MODE_BUSY_BIT = 1;
   localparam int MODE_SEL_BIT = 2;
   localparam int IRQ_SW_BIT = 0;
   localparam int IRQ_HW_BIT = 1;
   localparam int CODE_W = 8;
   localparam int TAPS = 256;
   localparam int CHANS = 6;
   localparam logic CTL_RST = 1'b0;
   localparam logic [7:0] CODE_RST = 8'h00;
   localparam logic [2:0] CHAN_RST = 3'h0;
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam logic [255:0] TAP_RST = 256'h1;
   localparam logic [7:0] HW_START_CODE = 8'h80;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int SETTLE_NS = 40;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CONV_CYC = CODE_W * SETTLE_CYC;

   typedef enum logic [2:0] {
      SAC_IDLE = 3'b001,
      SAC_SW = 3'b010,
      SAC_HW = 3'b100
   } sac_state_t;

endpackage : sac_pkg
`default_nettype wire

// ==== sac_seq_if.sv ====
// Link between the register front end and the compare sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sac_seq_if;
   logic sw_load;
   logic [7:0] load_data;
   logic hw_start;
   logic abort;
   logic cmp_bit;
   logic [7:0] code;
   logic busy;
   logic result;
   logic sw_done;
   logic hw_done;

   modport ctl (
      output sw_load, load_data, hw_start, abort, cmp_bit,
      input code, busy, result, sw_done, hw_done
   );
   modport seq (
      input sw_load, load_data, hw_start, abort, cmp_bit,
      output code, busy, result, sw_done, hw_done
   );
endinterface : sac_seq_if
`default_nettype wire

// ==== sac_seq.sv ====
// Compare sequencer: single software compares and the 8-step hardware search.
// Assumes cmp_bit is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module sac_seq (
   input wire logic clk,
   input wire logic rst_n,
   sac_seq_if.seq lk
);
   import sac_pkg::*;

   localparam logic [3:0] CNT_LOAD = 4'(SETTLE_CYC - 1);

   sac_state_t state_r;
   logic [3:0] cnt_r;
   logic [2:0] bit_r;
   logic [7:0] code_r;
   logic result_r;
   logic sw_done_r;
   logic hw_done_r;
   logic sw_go;
   logic step_sw;
   logic step_hw;

   assign sw_go = lk.sw_load && (state_r != SAC_HW);
   assign step_sw = (state_r == SAC_SW) && (cnt_r == 4'h0) && !lk.abort && !lk.hw_start && !sw_go;
   assign step_hw = (state_r == SAC_HW) && (cnt_r == 4'h0) && !lk.abort && !lk.hw_start;

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= SAC_IDLE;
      end else if (lk.abort) begin
         state_r <= SAC_IDLE;
      end else if (lk.hw_start) begin
         state_r <= SAC_HW;
      end else if (sw_go) begin
         state_r <= SAC_SW;
      end else if (step_sw || (step_hw && bit_r == 3'h0)) begin
         state_r <= SAC_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 4'h0;
      end else if (lk.hw_start || sw_go || cnt_r == 4'h0) begin
         cnt_r <= CNT_LOAD;
      end else if (state_r != SAC_IDLE) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Code register and search
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_r <= CODE_RST;
         bit_r <= 3'h7;
      end else if (lk.hw_start && !lk.abort) begin
         code_r <= HW_START_CODE;
         bit_r <= 3'h7;
      end else if (sw_go) begin
         code_r <= lk.load_data;
      end else if (step_hw) begin
         code_r[bit_r] <= lk.cmp_bit;
         if (bit_r != 3'h0) begin
            code_r[bit_r - 3'h1] <= 1'b1;
            bit_r <= bit_r - 3'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= 1'b0;
         sw_done_r <= 1'b0;
         hw_done_r <= 1'b0;
      end else begin
         if (step_sw || step_hw) begin
            result_r <= lk.cmp_bit;
         end
         sw_done_r <= step_sw;
         hw_done_r <= step_hw && (bit_r == 3'h0);
      end
   end

   assign lk.code = code_r;
   assign lk.busy = (state_r == SAC_HW);
   assign lk.result = result_r;
   assign lk.sw_done = sw_done_r;
   assign lk.hw_done = hw_done_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   start_code_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(lk.busy) |-> code_r == HW_START_CODE)
      else $error("search did not start at mid code");

   done_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      hw_done_r |-> !lk.busy && code_r[0] == $past(lk.cmp_bit))
      else $error("result moved at end of conversion");

endmodule : sac_seq
`default_nettype wire

// ==== sac_top.sv ====
// Successive-approximation converter control with APB registers.
// Assumes an external resistor string driven by tap_sel and a comparator on cmp_in.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sac_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sac_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmp_in,
   input wire logic ce_reset_in,
   input wire logic clk_stop_in,
   output logic [sac_pkg::TAPS-1:0] tap_sel,
   output logic [sac_pkg::CHANS-1:0] chan_en,
   output logic irq
);
   import sac_pkg::*;

   // ----------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------
   function automatic logic [2:0] reg_sel(input logic [11:0] a);
      logic [2:0] s;
      s = 3'h0;
      if (a == ADDR_CODE) begin
         s = 3'h1;
      end else if (a == ADDR_CHAN) begin
         s = 3'h2;
      end else if (a == ADDR_MODE) begin
         s = 3'h3;
      end else if (a == ADDR_ISTAT) begin
         s = 3'h4;
      end else if (a == ADDR_IMASK) begin
         s = 3'h5;
      end
      return s;
   endfunction : reg_sel

   function automatic logic [255:0] tap_dec(input logic [7:0] c);
      logic [255:0] t;
      t = '0;
      t[c] = 1'b1;
      return t;
   endfunction : tap_dec

   function automatic logic [5:0] chan_dec(input logic [2:0] c);
      logic [5:0] e;
      e = 6'h00;
      if (c != 3'h0 && c != 3'h7) begin
         e[c - 3'h1] = 1'b1;
      end
      return e;
   endfunction : chan_dec

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n_s;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_n_s <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_s <= rst_s1_r;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_s);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] async_in;
   logic [2:0] sy1_r;
   logic [2:0] sy2_r;
   logic cmp_s;
   logic ce_s;
   logic stop_s;

   assign async_in = {clk_stop_in, ce_reset_in, cmp_in};

   generate
      for (genvar i = 0; i < 3; i++) begin : g_sync
         always_ff @(posedge clk or negedge rst_n_s) begin
            if (!rst_n_s) begin
               sy1_r[i] <= 1'b0;
               sy2_r[i] <= 1'b0;
            end else begin
               sy1_r[i] <= async_in[i];
               sy2_r[i] <= sy1_r[i];
            end
         end
      end
   endgenerate

   assign cmp_s = sy2_r[0];
   assign ce_s = sy2_r[1];
   assign stop_s = sy2_r[2];

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic setup;
   logic wr_en;
   logic [2:0] wsel;
   logic [31:0] rd_nxt;
   logic [31:0] prdata_r;
   logic err_r;

   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite;
   assign wsel = reg_sel(paddr);
   assign pready = psel && penable;
   assign pslverr = psel && penable && err_r;
   assign prdata = prdata_r;

   sac_seq_if lk ();

   logic mode_r;
   logic [2:0] chan_r;
   logic [1:0] istat_r;
   logic [1:0] imask_r;

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (wsel)
         3'h1: rd_nxt[7:0] = lk.code;
         3'h2: rd_nxt[2:0] = chan_r;
         3'h3: begin
            rd_nxt[MODE_SEL_BIT] = mode_r;
            rd_nxt[MODE_BUSY_BIT] = lk.busy;
            rd_nxt[MODE_RES_BIT] = lk.result;
         end
         3'h4: rd_nxt[1:0] = istat_r;
         3'h5: rd_nxt[1:0] = imask_r;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         prdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
      end else if (setup) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
         err_r <= (wsel == 3'h0);
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic mode_wr;
   logic code_wr;

   assign mode_wr = wr_en && (wsel == 3'h3);
   assign code_wr = wr_en && (wsel == 3'h1);

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         mode_r <= CTL_RST;
      end else if (mode_wr) begin
         mode_r <= pwdata[MODE_SEL_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         chan_r <= CHAN_RST;
      end else if (wr_en && wsel == 3'h2) begin
         chan_r <= pwdata[2:0];
      end
   end

   // Sequencer requests; a local reset or clock stop holds the search off
   assign lk.abort = (mode_wr && !pwdata[MODE_SEL_BIT]) || ce_s || stop_s;
   assign lk.hw_start = mode_wr && pwdata[MODE_SEL_BIT] && !ce_s && !stop_s;
   assign lk.sw_load = code_wr && !mode_r;
   assign lk.load_data = pwdata[7:0];
   assign lk.cmp_bit = cmp_s;

   sac_seq u_seq (
      .clk(clk),
      .rst_n(rst_n_s),
      .lk(lk)
   );

   // ----------------------------------------------------------------
   // Analog drive
   // ----------------------------------------------------------------
   logic [255:0] tap_sel_r;
   logic [5:0] chan_en_r;

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         tap_sel_r <= TAP_RST;
      end else begin
         tap_sel_r <= tap_dec(lk.code);
      end
   end

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         chan_en_r <= 6'h00;
      end else begin
         chan_en_r <= chan_dec(chan_r);
      end
   end

   assign tap_sel = tap_sel_r;
   assign chan_en = chan_en_r;

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   logic [1:0] evt;
   logic [1:0] w1c;

   assign evt = {lk.hw_done, lk.sw_done};
   assign w1c = (wr_en && wsel == 3'h4) ? pwdata[1:0] : 2'h0;

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         istat_r <= IRQ_RST;
      end else begin
         istat_r <= (istat_r & ~w1c) | evt;
      end
   end

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         imask_r <= IRQ_RST;
      end else if (wr_en && wsel == 3'h5) begin
         imask_r <= pwdata[1:0];
      end
   end

   assign irq = |(istat_r & imask_r);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [6:0] busy_cnt_r;

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         busy_cnt_r <= 7'h00;
      end else if (lk.hw_start) begin
         // A restart begins a fresh count even while busy
         busy_cnt_r <= 7'h00;
      end else if (lk.busy) begin
         busy_cnt_r <= busy_cnt_r + 7'h01;
      end else begin
         busy_cnt_r <= 7'h00;
      end
   end

   tap_follow_a: assert property (
      $onehot(tap_sel_r) && tap_sel_r[$past(lk.code)])
      else $error("tap does not match code");

   one_channel_a: assert property ($onehot0(chan_en_r))
      else $error("more than one channel routed");

   hw_mode_a: assert property (lk.busy |-> mode_r)
      else $error("busy outside hardware mode");

   start_busy_a: assert property (lk.hw_start |=> lk.busy)
      else $error("write of one did not start conversion");

   abort_now_a: assert property (lk.abort |=> !lk.busy)
      else $error("abort did not stop conversion");

   busy_len_a: assert property (
      $fell(lk.busy) && !$past(lk.abort) |-> busy_cnt_r == CONV_CYC)
      else $error("conversion length wrong");

   busy_cap_a: assert property (lk.busy |-> busy_cnt_r < CONV_CYC)
      else $error("conversion overran");

   sw_compare_a: assert property (
      lk.sw_load && !lk.abort ##1 (!lk.sw_load && !lk.abort && !lk.hw_start)[*8]
      ##1 (!lk.sw_load && !lk.abort && !lk.hw_start)[*2] |-> ##1 lk.sw_done)
      else $error("software compare not done in time");

   sw_one_a: assert property (lk.sw_done |-> !lk.busy ##1 !lk.sw_done)
      else $error("software compare ran conversion");

   result_flag_a: assert property (lk.sw_done |-> lk.result == $past(cmp_s))
      else $error("result flag not comparator value");

   code_load_a: assert property (code_wr && !mode_r |=> lk.code == $past(pwdata[7:0]))
      else $error("code write not stored");

   hw_result_a: assert property (
      lk.hw_done |-> lk.code[0] == $past(cmp_s, 2) && !lk.busy)
      else $error("last bit not from comparator");

   local_rst_a: assert property ((ce_s || stop_s) |=> !lk.busy)
      else $error("local reset left conversion busy");

   cmp_path_a: assert property ($past(rst_n_s, 2) |-> lk.cmp_bit == $past(cmp_in, 2))
      else $error("comparator path broken");

endmodule : sac_top
`default_nettype wire

// ==== sac_cmp_model.sv ====
// Behavioural comparator and resistor-string tap reader facing the converter control.
// Assumes tap_sel is one-hot; the pin voltage sits half a step above pin_code.
`timescale 1ns/1ps
`default_nettype none
module sac_cmp_model (
   input wire logic [sac_pkg::TAPS-1:0] tap_sel,
   input wire logic [7:0] pin_code,
   output logic cmp_in
);
   import sac_pkg::*;
   int idx;
   always_comb begin
      idx = 0;
      for (int i = 0; i < TAPS; i++) begin
         if (tap_sel[i]) begin
            idx = i;
         end
      end
      // Half-step offset keeps the input off every tap, so no equality case arises
      cmp_in = (pin_code >= idx[7:0]);
   end
endmodule : sac_cmp_model
`default_nettype wire

// ==== sac_top_tb.sv ====
// Self-checking bench for the converter control: APB master, comparator model.
// Assumes the design's zero-wait APB slave and 10-cycle settle per compare step.
`timescale 1ns/1ps
`default_nettype none
module sac_top_tb;
   import sac_pkg::*;
   typedef struct packed {
      logic [7:0] code;
      logic [7:0] pin;
      logic res;
   } sac_row_t;
   localparam sac_row_t ROWS [6] = '{'{8'h40, 8'h80, 1'b1}, '{8'h80, 8'h40, 1'b0},
      '{8'h55, 8'h55, 1'b1}, '{8'hff, 8'hfe, 1'b0}, '{8'h00, 8'h00, 1'b1},
      '{8'h7f, 8'h80, 1'b1}};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cmp_in;
   logic ce_reset_in = 1'b0;
   logic clk_stop_in = 1'b0;
   logic [TAPS-1:0] tap_sel;
   logic [CHANS-1:0] chan_en;
   logic irq;
   logic [7:0] pin_code = 8'h00;
   logic [31:0] q;
   logic e;
   int n_errors = 0;
   int total_checks = 0;

   sac_top sac_top_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_in(cmp_in), .ce_reset_in(ce_reset_in),
      .clk_stop_in(clk_stop_in), .tap_sel(tap_sel), .chan_en(chan_en), .irq(irq));
   sac_cmp_model sac_cmp_model_inst (.tap_sel(tap_sel), .pin_code(pin_code), .cmp_in(cmp_in));

   initial begin
      forever #2 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_errors++;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_cyc

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      wait_cyc(12);
      rstn <= 1'b1;
      wait_cyc(3);
      apb(1'b0, ADDR_MODE, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, ADDR_CODE, 32'h0);
      chk(q, 32'h0);
      chk(tap_sel, 256'h1);
      apb(1'b1, ADDR_IMASK, 32'h3);
      foreach (ROWS[i]) begin
         pin_code <= ROWS[i].pin;
         apb(1'b1, ADDR_CODE, {24'h0, ROWS[i].code});
         wait_cyc(12);
         chk(tap_sel, 256'h1 << ROWS[i].code);
         apb(1'b0, ADDR_MODE, 32'h0);
         chk(q[MODE_RES_BIT], ROWS[i].res);
         chk(irq, 1'b1);
         apb(1'b1, ADDR_ISTAT, 32'h1);
         wait_cyc(1);
         chk(irq, 1'b0);
      end
      // Full hardware conversion, then ignored code write and masked interrupt
      pin_code <= 8'ha7;
      apb(1'b1, ADDR_MODE, 32'h4);
      apb(1'b0, ADDR_MODE, 32'h0);
      chk(q[MODE_BUSY_BIT], 1'b1);
      wait_cyc(CONV_CYC);
      apb(1'b0, ADDR_MODE, 32'h0);
      chk(q[MODE_BUSY_BIT], 1'b0);
      apb(1'b1, ADDR_CODE, 32'h11);
      apb(1'b0, ADDR_CODE, 32'h0);
      chk(q, 32'ha7);
      apb(1'b0, ADDR_ISTAT, 32'h0);
      chk(q[IRQ_HW_BIT], 1'b1);
      chk(irq, 1'b1);
      apb(1'b1, ADDR_IMASK, 32'h0);
      wait_cyc(1);
      chk(irq, 1'b0);
      apb(1'b1, ADDR_ISTAT, 32'h3);
      // Abort by mode write, then by local reset and clock stop
      apb(1'b1, ADDR_MODE, 32'h4);
      wait_cyc(25);
      apb(1'b1, ADDR_MODE, 32'h0);
      apb(1'b0, ADDR_MODE, 32'h0);
      chk(q[MODE_BUSY_BIT], 1'b0);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, ADDR_MODE, 32'h4);
         wait_cyc(20);
         if (k == 0) begin
            ce_reset_in <= 1'b1;
         end else begin
            clk_stop_in <= 1'b1;
         end
         wait_cyc(5);
         apb(1'b0, ADDR_MODE, 32'h0);
         chk(q[MODE_SEL_BIT], 1'b1);
         chk(q[MODE_BUSY_BIT], 1'b0);
         ce_reset_in <= 1'b0;
         clk_stop_in <= 1'b0;
      end
      wait_cyc(85);
      apb(1'b0, ADDR_ISTAT, 32'h0);
      chk(q[IRQ_HW_BIT], 1'b0);
      // Channel routing for every selector value
      for (int v = 0; v < 8; v++) begin
         apb(1'b1, ADDR_CHAN, 32'(v));
         wait_cyc(2);
         chk(chan_en, (v >= 1 && v <= 6) ? (32'h1 << (v - 1)) : 32'h0);
      end
      // Unmapped address
      apb(1'b0, 12'hffc, 32'h0);
      chk(e, 1'b1);
      chk(q, 32'h0);
      // Reset in hardware mode, with no conversion busy, clears the mode bit
      rstn <= 1'b0;
      wait_cyc(2);
      rstn <= 1'b1;
      wait_cyc(3);
      apb(1'b0, ADDR_MODE, 32'h0);
      chk(q, 32'h0);
      finish_test();
   end

   initial begin
      #200000;
      n_errors++;
      finish_test();
   end
endmodule : sac_top_tb
`default_nettype wire
